// ### hw/dcfc_pkg.sv
// Constants, defaults and types shared by the dual-clock FIFO port control.
// Assumes one system clock that samples both FIFO clock pins.
package dcfc_pkg;

  // ==========================================================
  // Data path and storage
  localparam int DATA_W = 18;
  localparam int BYTE_W = 9;
  localparam int PAY_W = DATA_W - 2;
  localparam int ADDR_W = 9;
  localparam int PTR_W = ADDR_W + 1;
  localparam int CAP = 512;
  localparam logic [PTR_W-1:0] CAP_UNITS = 10'h200;
  localparam logic [PTR_W-1:0] HALF_UNITS = 10'h100;
  localparam logic [PTR_W-1:0] PTR_ONE = 10'h001;

  // ==========================================================
  // Pin synchroniser
  localparam int PIN_CTRL_N = 18;
  localparam int SYNC_W = DATA_W + PIN_CTRL_N;

  // ==========================================================
  // Flag offsets
  localparam int OFS_W = 10;
  localparam int NUM_DEFAULTS = 8;
  localparam logic [OFS_W-1:0] DEF_EMPTY_OFS [NUM_DEFAULTS] = '{
    10'h007, 10'h01f, 10'h03f, 10'h07f,
    10'h00f, 10'h03f, 10'h0ff, 10'h001};
  localparam logic [OFS_W-1:0] DEF_FULL_OFS [NUM_DEFAULTS] = '{
    10'h007, 10'h01f, 10'h03f, 10'h07f,
    10'h00f, 10'h03f, 10'h0ff, 10'h001};

  // ==========================================================
  // Register map, byte addresses
  localparam int AVS_ADDR_W = 4;
  localparam logic [AVS_ADDR_W-1:0] REG_STATUS = 4'h0;
  localparam logic [AVS_ADDR_W-1:0] REG_FILL = 4'h4;
  localparam logic [AVS_ADDR_W-1:0] REG_CONTROL = 4'h8;
  localparam int CTRL_FLUSH_BIT = 0;
  localparam int STATUS_W = 15;

  // ==========================================================
  // Byte phase of a split output word
  typedef enum logic {DCFC_PH_FIRST, DCFC_PH_SECOND} dcfc_phase_t;

endpackage : dcfc_pkg

// ### hw/dcfc_pin_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes every bit is independent and slower than the system clock.
`timescale 1ns/1ns
`default_nettype none
module dcfc_pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Pins in, filtered levels out
  input wire logic [WIDTH-1:0] pin_raw,
  output logic [WIDTH-1:0] pin_q
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_pin_q;

  // A bit changes only once the second and third stages agree.
  always_comb
  begin
    for (int i = 0; i < WIDTH; i++)
    begin
      next_pin_q[i] = (stage2[i] == stage3[i]) ? stage3[i] : pin_q[i];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      pin_q <= '0;
    end
    else
    begin
      stage1 <= pin_raw;
      stage2 <= stage1;
      stage3 <= stage2;
      pin_q <= next_pin_q;
    end
  end

endmodule : dcfc_pin_sync
`default_nettype wire

// ### hw/dcfc_port_ctrl.sv
// Write and read port control of a dual-clock bus-matching FIFO.
// Assumes both FIFO clock pins are far slower than clk_sys and sampled here.
`timescale 1ns/1ns
`default_nettype none

// How it works
// - Gate low and not full: each write edge stores the next word.
// - Standard full flag low at full; clears two write edges after a read.
// - Fall-through input-ready high at full; clears two write edges after a read.
// - Write gate is ignored when full; writer ties it low in async write.
// - Read edges start read cycles; no read edges, no empty or ready flag change, except empty in async read.
// - Read edges only raise the half flag; clocks may be unrelated or equal.
// - Async read: each strobe edge moves a word out; gate tied low.
// - Gate low and not empty: each read edge loads the output register.
// - Gate high: the output register and outputs hold the last word, except a fall-through first word.
// - Standard mode reads every word; empty low after last; gate low needed unless async.
// - Standard empty flag returns high two read edges after a write.
// - Fall-through: first word shows on the third read edge, ungated.
// - Output-ready rises only on a true read after the last word.
// - Serial method, both gates low: one serial bit per write edge.
// - Output enable low drives the data bus; high releases it.
// - Access and two selects at reset choose defaults and load method.
// - Access low allows offset loads by the chosen method; reads parallel.
// - Width selects at reset set bus widths; flags count widest units.
// - Byte order at reset: low sends the high byte first, high the low.
// - Timing low: almost flags set on one side, cleared on the other.
// - Timing high: each almost flag updates on its own side only.
// - Parity position shapes parallel offset words only, not FIFO data.
// - Mode pin at reset picks fall-through; later it is serial input.
// - Async write: each strobe edge stores a word; gate tied low.
module dcfc_port_ctrl (
  // System clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Write port pins
  input wire logic write_clk,
  input wire logic write_gate_n,
  input wire logic [dcfc_pkg::DATA_W-1:0] data_in,
  // Read port pins
  input wire logic read_clk,
  input wire logic read_gate_n,
  input wire logic output_enable_n,
  // Offset programming pins
  input wire logic serial_load_gate_n,
  input wire logic offset_access_n,
  input wire logic fall_through_mode_serial_in,
  // Master reset and strap pins
  input wire logic full_reset_n,
  input wire logic default_offset_select_0,
  input wire logic default_offset_select_1,
  input wire logic input_width_select,
  input wire logic output_width_select,
  input wire logic byte_order_select,
  input wire logic flag_timing_select,
  input wire logic parity_position_select,
  input wire logic read_port_async_select_n,
  input wire logic write_port_async_select_n,
  // Data out
  output logic [dcfc_pkg::DATA_W-1:0] data_out,
  output logic data_out_oe,
  // Flags
  output logic full_indicator_n,
  output logic space_available_n,
  output logic empty_indicator_n,
  output logic output_ready_n,
  output logic almost_empty_flag_n,
  output logic almost_full_flag_n,
  output logic half_level_flag_n,
  // Avalon-MM slave
  input wire logic [dcfc_pkg::AVS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  import dcfc_pkg::*;

  // ==========================================================
  // Pin synchronisation
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] pin_q;
  logic s_wclk, s_wgate_n, s_rclk, s_rgate_n, s_oe_n, s_sen_n, s_ld_n;
  logic s_mrs_n, s_si, s_default_offset_select_1, s_default_offset_select_0, s_iw, s_ow, s_be, s_pfm, s_ip;
  logic s_read_port_async_select_n_n, s_write_port_async_select_n_n;
  logic [DATA_W-1:0] s_din;

  assign pin_raw = {write_clk, write_gate_n, data_in, read_clk, read_gate_n,
    output_enable_n, serial_load_gate_n, offset_access_n, full_reset_n,
    fall_through_mode_serial_in, default_offset_select_1,
    default_offset_select_0, input_width_select, output_width_select,
    byte_order_select, flag_timing_select, parity_position_select,
    read_port_async_select_n, write_port_async_select_n};
  assign {s_wclk, s_wgate_n, s_din, s_rclk, s_rgate_n, s_oe_n, s_sen_n,
    s_ld_n, s_mrs_n, s_si, s_default_offset_select_1, s_default_offset_select_0, s_iw, s_ow, s_be, s_pfm, s_ip,
    s_read_port_async_select_n_n, s_write_port_async_select_n_n} = pin_q;

  dcfc_pin_sync #(.WIDTH(SYNC_W)) u_pin_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .pin_raw(pin_raw),
    .pin_q(pin_q)
  );

  // ==========================================================
  // State declarations
  logic cfg_fwft, cfg_serial, cfg_iw9, cfg_ow9, cfg_le, cfg_pfm_sync, cfg_ip;
  logic cfg_async_rd, cfg_async_wr, w_ofs_sel;
  logic [OFS_W-1:0] empty_off, full_off;
  logic next_cfg_fwft, next_cfg_serial, next_cfg_iw9, next_cfg_ow9;
  logic next_cfg_le, next_cfg_pfm_sync, next_cfg_ip, next_cfg_async_rd;
  logic next_cfg_async_wr, next_w_ofs_sel;
  logic [OFS_W-1:0] next_empty_off, next_full_off;

  logic [PTR_W-1:0] wptr, rptr_w1, rptr_w2, next_wptr, next_rptr_w1;
  logic [PTR_W-1:0] next_rptr_w2;
  logic full_q, paf_n, hf_n, w_half, wclk_prev, w_edge_d;
  logic next_full_q, next_paf_n, next_hf_n, next_w_half, next_wclk_prev;
  logic [BYTE_W-1:0] w_hold, next_w_hold;

  logic [PTR_W-1:0] rptr, wptr_r1, wptr_r2, next_rptr, next_wptr_r1;
  logic [PTR_W-1:0] next_wptr_r2;
  logic ef_q, out_valid, pae_n, r_ofs_sel, rclk_prev, r_edge_d;
  logic next_ef_q, next_out_valid, next_pae_n, next_r_ofs_sel;
  logic next_rclk_prev;
  logic [DATA_W-1:0] out_reg, out_word, next_out_reg, next_out_word;
  dcfc_phase_t phase, next_phase;

  logic ack, flush, next_ack, next_flush;
  logic [31:0] rdata, next_rdata;

  logic [DATA_W-1:0] mem [CAP];
  logic mem_we;
  logic [DATA_W-1:0] mem_wdata;
  logic [DATA_W-1:0] mem_q;

  logic w_edge, r_edge, fifo_rst, in_pack, out_split;
  logic [PTR_W-1:0] fill_now;
  logic [STATUS_W-1:0] status;

  assign w_edge = s_wclk & ~wclk_prev;
  assign r_edge = s_rclk & ~rclk_prev;
  assign fifo_rst = ~s_mrs_n | flush;
  assign in_pack = cfg_iw9 & ~cfg_ow9;
  assign out_split = ~cfg_iw9 & cfg_ow9;
  assign fill_now = wptr - rptr;
  assign mem_q = mem[rptr[ADDR_W-1:0]];

  // Parallel offset word to offset value, skipping parity positions.
  function automatic logic [OFS_W-1:0] ofs_from_bus(
    input logic [DATA_W-1:0] d, input logic ip);
    logic [PAY_W-1:0] t;
    t = ip ? {d[DATA_W-2:BYTE_W], d[BYTE_W-2:0]} : d[PAY_W-1:0];
    return t[OFS_W-1:0];
  endfunction : ofs_from_bus

  // Offset value to parallel word; parity positions read as zero.
  function automatic logic [DATA_W-1:0] ofs_to_bus(
    input logic [OFS_W-1:0] v, input logic ip);
    logic [PAY_W-1:0] t;
    t = PAY_W'(v);
    if (ip)
      return {1'b0, t[PAY_W-1:BYTE_W-1], 1'b0, t[BYTE_W-2:0]};
    else
      return {2'b00, t};
  endfunction : ofs_to_bus

  // ==========================================================
  // Configuration and offset registers
  always_comb
  begin
    next_cfg_fwft = cfg_fwft;
    next_cfg_serial = cfg_serial;
    next_cfg_iw9 = cfg_iw9;
    next_cfg_ow9 = cfg_ow9;
    next_cfg_le = cfg_le;
    next_cfg_pfm_sync = cfg_pfm_sync;
    next_cfg_ip = cfg_ip;
    next_cfg_async_rd = cfg_async_rd;
    next_cfg_async_wr = cfg_async_wr;
    next_empty_off = empty_off;
    next_full_off = full_off;
    next_w_ofs_sel = s_ld_n ? 1'b0 : w_ofs_sel;
    if (!s_mrs_n)
    begin
      // Mode strap; async ports force standard mode
      next_cfg_fwft = s_si & s_read_port_async_select_n_n & s_write_port_async_select_n_n;
      next_cfg_serial = s_ld_n;
      next_empty_off = DEF_EMPTY_OFS[{s_ld_n, s_default_offset_select_1, s_default_offset_select_0}];
      next_full_off = DEF_FULL_OFS[{s_ld_n, s_default_offset_select_1, s_default_offset_select_0}];
      next_cfg_iw9 = s_iw;
      next_cfg_ow9 = s_ow;
      next_cfg_le = s_be;
      next_cfg_pfm_sync = s_pfm;
      next_cfg_ip = s_ip;
      next_cfg_async_rd = ~s_read_port_async_select_n_n;
      next_cfg_async_wr = ~s_write_port_async_select_n_n;
      next_w_ofs_sel = 1'b0;
    end
    else if (w_edge & cfg_serial & ~s_sen_n & ~s_ld_n)
    begin
      {next_full_off, next_empty_off} = {s_si, full_off,
        empty_off[OFS_W-1:1]};
    end
    else if (w_edge & ~cfg_serial & ~s_ld_n & (cfg_async_wr | ~s_wgate_n))
    begin
      if (w_ofs_sel)
        next_full_off = ofs_from_bus(s_din, cfg_ip);
      else
        next_empty_off = ofs_from_bus(s_din, cfg_ip);
      next_w_ofs_sel = ~w_ofs_sel;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_fwft <= 1'b0;
      cfg_serial <= 1'b0;
      cfg_iw9 <= 1'b0;
      cfg_ow9 <= 1'b0;
      cfg_le <= 1'b0;
      cfg_pfm_sync <= 1'b0;
      cfg_ip <= 1'b0;
      cfg_async_rd <= 1'b0;
      cfg_async_wr <= 1'b0;
      empty_off <= '0;
      full_off <= '0;
      w_ofs_sel <= 1'b0;
    end
    else
    begin
      cfg_fwft <= next_cfg_fwft;
      cfg_serial <= next_cfg_serial;
      cfg_iw9 <= next_cfg_iw9;
      cfg_ow9 <= next_cfg_ow9;
      cfg_le <= next_cfg_le;
      cfg_pfm_sync <= next_cfg_pfm_sync;
      cfg_ip <= next_cfg_ip;
      cfg_async_rd <= next_cfg_async_rd;
      cfg_async_wr <= next_cfg_async_wr;
      empty_off <= next_empty_off;
      full_off <= next_full_off;
      w_ofs_sel <= next_w_ofs_sel;
    end
  end

  // ==========================================================
  // Write side
  always_comb
  begin
    logic [PTR_W-1:0] seen;
    logic [PTR_W-1:0] fill_next;
    logic [PTR_W-1:0] thr;
    seen = '0;
    fill_next = '0;
    thr = CAP_UNITS - full_off;
    next_wptr = wptr;
    next_rptr_w1 = rptr_w1;
    next_rptr_w2 = rptr_w2;
    next_full_q = full_q;
    next_paf_n = paf_n;
    next_hf_n = hf_n;
    next_w_half = w_half;
    next_w_hold = w_hold;
    next_wclk_prev = s_wclk;
    mem_we = 1'b0;
    mem_wdata = s_din;
    // Read pointer seen after two write edges
    if (w_edge)
    begin
      next_rptr_w1 = rptr;
      next_rptr_w2 = rptr_w1;
    end
    if (w_edge & (cfg_async_wr | ~s_wgate_n) & s_ld_n & ~full_q)
    begin
      if (in_pack & ~w_half)
      begin
        next_w_hold = s_din[BYTE_W-1:0];
        next_w_half = 1'b1;
      end
      else
      begin
        mem_we = 1'b1;
        next_wptr = wptr + PTR_ONE;
        next_w_half = 1'b0;
        // First byte is high byte in big-endian
        if (in_pack)
          mem_wdata = cfg_le ? {s_din[BYTE_W-1:0], w_hold}
                             : {w_hold, s_din[BYTE_W-1:0]};
      end
    end
    seen = cfg_async_wr ? rptr : next_rptr_w2;
    fill_next = next_wptr - seen;
    if (w_edge | cfg_async_wr)
      next_full_q = (fill_next == CAP_UNITS);
    if (cfg_pfm_sync)
    begin
      if (w_edge)
        next_paf_n = ~(fill_next >= thr);
    end
    // Set by writes, cleared by reads
    else if (w_edge_d & (fill_now >= thr))
      next_paf_n = 1'b0;
    else if (r_edge_d & (fill_now < thr))
      next_paf_n = 1'b1;
    // Read edges only raise half flag
    if (w_edge_d & (fill_now > HALF_UNITS))
      next_hf_n = 1'b0;
    else if (r_edge_d & (fill_now <= HALF_UNITS))
      next_hf_n = 1'b1;
    if (fifo_rst)
    begin
      next_wptr = '0;
      next_rptr_w1 = '0;
      next_rptr_w2 = '0;
      next_full_q = 1'b0;
      next_paf_n = 1'b1;
      next_hf_n = 1'b1;
      next_w_half = 1'b0;
      mem_we = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wptr <= '0;
      rptr_w1 <= '0;
      rptr_w2 <= '0;
      full_q <= 1'b0;
      paf_n <= 1'b1;
      hf_n <= 1'b1;
      w_half <= 1'b0;
      w_hold <= '0;
      wclk_prev <= 1'b0;
      w_edge_d <= 1'b0;
    end
    else
    begin
      wptr <= next_wptr;
      rptr_w1 <= next_rptr_w1;
      rptr_w2 <= next_rptr_w2;
      full_q <= next_full_q;
      paf_n <= next_paf_n;
      hf_n <= next_hf_n;
      w_half <= next_w_half;
      w_hold <= next_w_hold;
      wclk_prev <= next_wclk_prev;
      w_edge_d <= w_edge;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (mem_we)
      mem[wptr[ADDR_W-1:0]] <= mem_wdata;
  end

  // ==========================================================
  // Read side
  always_comb
  begin
    logic avail;
    logic advance;
    logic [PTR_W-1:0] seen_next;
    logic [PTR_W-1:0] fill_r;
    avail = 1'b0;
    advance = 1'b0;
    seen_next = '0;
    fill_r = '0;
    next_rptr = rptr;
    next_wptr_r1 = wptr_r1;
    next_wptr_r2 = wptr_r2;
    next_ef_q = ef_q;
    next_out_valid = out_valid;
    next_pae_n = pae_n;
    next_out_reg = out_reg;
    next_out_word = out_word;
    next_phase = phase;
    next_r_ofs_sel = s_ld_n ? 1'b0 : r_ofs_sel;
    next_rclk_prev = s_rclk;
    // Write pointer seen after two read edges
    if (r_edge)
    begin
      next_wptr_r1 = wptr;
      next_wptr_r2 = wptr_r1;
    end
    avail = (cfg_async_rd ? wptr : wptr_r2) != rptr;
    advance = r_edge & s_ld_n & (cfg_fwft ? (~out_valid | ~s_rgate_n)
                                          : (cfg_async_rd | ~s_rgate_n));
    // Without advance or an offset read the output register holds
    if (advance)
    begin
      if (phase == DCFC_PH_SECOND)
      begin
        next_out_reg = DATA_W'(cfg_le ? out_word[DATA_W-1:BYTE_W]
                                      : out_word[BYTE_W-1:0]);
        next_phase = DCFC_PH_FIRST;
      end
      else if (avail)
      begin
        next_rptr = rptr + PTR_ONE;
        next_out_word = mem_q;
        next_out_valid = 1'b1;
        next_out_reg = mem_q;
        if (out_split)
        begin
          next_out_reg = DATA_W'(cfg_le ? mem_q[BYTE_W-1:0]
                                        : mem_q[DATA_W-1:BYTE_W]);
          next_phase = DCFC_PH_SECOND;
        end
      end
      // True read after last word drops ready
      else if (cfg_fwft)
        next_out_valid = 1'b0;
    end
    if (r_edge & ~s_ld_n & (cfg_async_rd | ~s_rgate_n))
    begin
      next_out_reg = ofs_to_bus(r_ofs_sel ? full_off : empty_off, cfg_ip);
      next_r_ofs_sel = ~r_ofs_sel;
    end
    seen_next = cfg_async_rd ? wptr : next_wptr_r2;
    fill_r = seen_next - next_rptr;
    if (r_edge | cfg_async_rd)
      next_ef_q = (fill_r != '0) | (next_phase == DCFC_PH_SECOND);
    if (cfg_pfm_sync)
    begin
      if (r_edge)
        next_pae_n = ~(fill_r <= empty_off);
    end
    // Set by reads, cleared by writes
    else if (r_edge_d & (fill_now <= empty_off))
      next_pae_n = 1'b0;
    else if (w_edge_d & (fill_now > empty_off))
      next_pae_n = 1'b1;
    if (fifo_rst)
    begin
      next_rptr = '0;
      next_wptr_r1 = '0;
      next_wptr_r2 = '0;
      next_ef_q = 1'b0;
      next_out_valid = 1'b0;
      next_pae_n = 1'b0;
      next_out_reg = '0;
      next_out_word = '0;
      next_phase = DCFC_PH_FIRST;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rptr <= '0;
      wptr_r1 <= '0;
      wptr_r2 <= '0;
      ef_q <= 1'b0;
      out_valid <= 1'b0;
      pae_n <= 1'b0;
      out_reg <= '0;
      out_word <= '0;
      phase <= DCFC_PH_FIRST;
      r_ofs_sel <= 1'b0;
      rclk_prev <= 1'b0;
      r_edge_d <= 1'b0;
    end
    else
    begin
      rptr <= next_rptr;
      wptr_r1 <= next_wptr_r1;
      wptr_r2 <= next_wptr_r2;
      ef_q <= next_ef_q;
      out_valid <= next_out_valid;
      pae_n <= next_pae_n;
      out_reg <= next_out_reg;
      out_word <= next_out_word;
      phase <= next_phase;
      r_ofs_sel <= next_r_ofs_sel;
      rclk_prev <= next_rclk_prev;
      r_edge_d <= r_edge;
    end
  end

  // ==========================================================
  // Outputs
  assign data_out = out_reg;
  assign data_out_oe = ~s_oe_n;
  assign full_indicator_n = cfg_fwft | ~full_q;
  assign space_available_n = cfg_fwft & full_q;
  assign empty_indicator_n = cfg_fwft | ef_q;
  assign output_ready_n = ~cfg_fwft | ~out_valid;
  assign almost_empty_flag_n = pae_n;
  assign almost_full_flag_n = paf_n;
  assign half_level_flag_n = hf_n;

  // ==========================================================
  // Avalon-MM slave, one wait state per access
  assign status = {cfg_async_wr, cfg_async_rd, cfg_ip, cfg_pfm_sync, cfg_le,
    cfg_ow9, cfg_iw9, cfg_serial, cfg_fwft, ~hf_n, ~paf_n, ~pae_n,
    out_valid, ~ef_q, full_q};
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign avs_readdata = rdata;

  always_comb
  begin
    next_ack = (avs_read | avs_write) & ~ack;
    next_rdata = rdata;
    next_flush = flush;
    if (avs_read & ~ack)
    begin
      unique case (avs_address)
        REG_STATUS: next_rdata = 32'(status);
        REG_FILL: next_rdata = 32'(fill_now);
        REG_CONTROL: next_rdata = 32'(flush);
        default: next_rdata = '0;
      endcase
    end
    if (avs_write & ack & (avs_address == REG_CONTROL) & avs_byteenable[0])
      next_flush = avs_writedata[CTRL_FLUSH_BIT];
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ack <= 1'b0;
      rdata <= '0;
      flush <= 1'b0;
    end
    else
    begin
      ack <= next_ack;
      rdata <= next_rdata;
      flush <= next_flush;
    end
  end

endmodule : dcfc_port_ctrl
`default_nettype wire

// ### verif/dcfc_port_ctrl_chk.sv
// Concurrent checks on the FIFO port control pins.
// Assumes pin clocks stay steady for at least eight clk_sys cycles.
`timescale 1ns/1ns
`default_nettype none
module dcfc_port_ctrl_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Watched inputs
  input wire logic write_clk,
  input wire logic read_clk,
  input wire logic output_enable_n,
  input wire logic full_reset_n,
  input wire logic avs_write,
  // Watched outputs
  input wire logic [dcfc_pkg::DATA_W-1:0] data_out,
  input wire logic data_out_oe,
  input wire logic full_indicator_n,
  input wire logic space_available_n,
  input wire logic empty_indicator_n,
  input wire logic output_ready_n
);
  import dcfc_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // Pin, data and flag relations
  oe_on_a: assert property ((!output_enable_n)[*8] |-> data_out_oe)
    else $error("data bus not driven");
  oe_off_a: assert property (output_enable_n[*8] |-> !data_out_oe)
    else $error("data bus not released");
  rd_hold_a: assert property (
    (!read_clk && full_reset_n && !avs_write)[*8] |=> $stable(data_out))
    else $error("output word moved without a read edge");
  rd_flags_a: assert property (
    (!read_clk && full_reset_n && !avs_write)[*8]
    |=> $stable(empty_indicator_n) && $stable(output_ready_n))
    else $error("read flag moved without a read edge");
  wr_flags_a: assert property (
    (!write_clk && full_reset_n && !avs_write)[*8]
    |=> $stable(full_indicator_n) && $stable(space_available_n))
    else $error("write flag moved without a write edge");
  std_full_a: assert property (
    !full_indicator_n |-> !space_available_n && output_ready_n)
    else $error("full flag in wrong mode");
  fwft_ready_a: assert property (
    !output_ready_n |-> full_indicator_n && empty_indicator_n)
    else $error("ready flag in wrong mode");
  std_empty_a: assert property (
    !empty_indicator_n |-> output_ready_n && !space_available_n)
    else $error("empty flag in wrong mode");
endmodule : dcfc_port_ctrl_chk
`default_nettype wire

// ### verif/dcfc_far_model.sv
// Writer and reader logic on the FIFO pin side.
// Assumes clk_sys paces it; pins change right after its rising edge.
`timescale 1ns/1ns
`default_nettype none
module dcfc_far_model (
  // Clock
  input wire logic clk_sys,
  // Writer pins
  output logic write_clk,
  output logic write_gate_n,
  output logic [dcfc_pkg::DATA_W-1:0] data_in,
  // Reader pins
  output logic read_clk,
  output logic read_gate_n
);
  import dcfc_pkg::*;
  initial {write_clk, read_clk, write_gate_n, read_gate_n} = 4'h3;
  initial data_in = '0;
  // Data is released to its inverse so stale words never look valid.
  task automatic wr(input logic g, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    write_gate_n <= g;
    data_in <= d;
    repeat (7) @(posedge clk_sys);
    write_clk <= 1'h1;
    repeat (7) @(posedge clk_sys);
    write_clk <= 1'h0;
    write_gate_n <= 1'h1;
    data_in <= ~d;
  endtask : wr
  task automatic rd(input logic g);
    @(posedge clk_sys);
    read_gate_n <= g;
    repeat (9) @(posedge clk_sys);
    read_clk <= 1'h1;
    repeat (9) @(posedge clk_sys);
    read_clk <= 1'h0;
    read_gate_n <= 1'h1;
  endtask : rd
endmodule : dcfc_far_model
`default_nettype wire

// ### verif/test_dcfc_port_ctrl.sv
// Self-checking bench for the FIFO port control block.
// Assumes the far-side model paces the FIFO pin clocks.
`timescale 1ns/1ns
`default_nettype none
module test_dcfc_port_ctrl;
  import dcfc_pkg::*;
  logic clk_sys = 1'h0, reset_n = 1'h0, full_reset_n = 1'h1, fall = 1'h0;
  logic output_enable_n = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
  logic [8:0] straps = 9'h180;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic write_clk, write_gate_n, read_clk, read_gate_n, data_out_oe;
  logic full_indicator_n, space_available_n, empty_indicator_n;
  logic output_ready_n, avs_waitrequest, almost_empty_flag_n;
  logic almost_full_flag_n, half_level_flag_n;
  logic [DATA_W-1:0] data_in, data_out, msk, w[4], expq[$];
  int miscompares = 0, checks = 0, cyc = 0, seed;
  event got;
  always #5 clk_sys = ~clk_sys;
  dcfc_far_model i_far (.*);
  dcfc_port_ctrl i_dut (.*, .serial_load_gate_n(1'h1),
    .offset_access_n(1'h1), .fall_through_mode_serial_in(fall),
    .default_offset_select_0(straps[0]),
    .default_offset_select_1(straps[1]), .input_width_select(straps[2]),
    .output_width_select(straps[3]), .byte_order_select(straps[4]),
    .flag_timing_select(straps[5]), .parity_position_select(straps[6]),
    .read_port_async_select_n(straps[7]),
    .write_port_async_select_n(straps[8]), .avs_byteenable(4'hf));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  task automatic rdx(input logic g, input logic [DATA_W-1:0] e);
    expq.push_back(e);
    i_far.rd(g);
    ->got;
  endtask : rdx
  task automatic bus(input logic wr, input logic [3:0] a, input logic d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {31'h0, d};
    do @(posedge clk_sys); while (avs_waitrequest !== 1'h0);
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask : bus
  task automatic mr(input logic fw, input logic [8:0] s);
    @(posedge clk_sys);
    full_reset_n <= 1'h0;
    fall <= fw;
    straps <= s;
    repeat (8) @(posedge clk_sys);
    full_reset_n <= 1'h1;
    repeat (8) @(posedge clk_sys);
  endtask : mr
  always @(got) chk(32'(data_out & msk), 32'(expq.pop_front() & msk));
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial
  begin
    seed = 32'he53836fc;
    msk = '1;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'h1;
    mr(1'h0, 9'h180);
    for (int i = 0; i < 4; i++)
    begin
      w[i] = DATA_W'($random(seed));
      i_far.wr(i == 3, w[i]);
    end
    chk(32'(empty_indicator_n), 32'h0);
    rdx(1'h1, '0);
    rdx(1'h1, '0);
    chk(32'(empty_indicator_n), 32'h1);
    rdx(1'h0, w[0]);
    rdx(1'h1, w[0]);
    rdx(1'h0, w[1]);
    rdx(1'h0, w[2]);
    rdx(1'h0, w[2]);
    chk(32'(empty_indicator_n), 32'h0);
    for (int i = 0; i <= CAP; i++)
      i_far.wr(1'h0, DATA_W'(i));
    chk(32'(full_indicator_n), 32'h0);
    chk(32'({almost_empty_flag_n, almost_full_flag_n,
      half_level_flag_n}), 32'h4);
    bus(1'h0, REG_FILL, 1'h0);
    chk(q, 32'h200);
    rdx(1'h1, w[2]);
    rdx(1'h1, w[2]);
    rdx(1'h0, '0);
    i_far.wr(1'h1, '0);
    chk(32'(full_indicator_n), 32'h0);
    i_far.wr(1'h1, '0);
    chk(32'(full_indicator_n), 32'h1);
    bus(1'h0, 4'hc, 1'h0);
    chk(q, 32'h0);
    bus(1'h1, REG_CONTROL, 1'h1);
    bus(1'h1, REG_CONTROL, 1'h0);
    chk(32'(empty_indicator_n), 32'h0);
    msk = 18'h1ff;
    for (int b = 0; b < 2; b++)
    begin
      mr(1'h0, b ? 9'h198 : 9'h188);
      i_far.wr(1'h0, w[3]);
      rdx(1'h1, '0);
      rdx(1'h1, '0);
      rdx(1'h0, b ? w[3] : w[3] >> 9);
      rdx(1'h0, b ? w[3] >> 9 : w[3]);
    end
    msk = '1;
    mr(1'h1, 9'h180);
    i_far.wr(1'h0, w[0]);
    i_far.wr(1'h0, w[1]);
    rdx(1'h1, '0);
    rdx(1'h1, '0);
    rdx(1'h1, w[0]);
    chk(32'(output_ready_n), 32'h0);
    rdx(1'h0, w[1]);
    rdx(1'h0, w[1]);
    chk(32'(output_ready_n), 32'h1);
    output_enable_n <= 1'h1;
    repeat (10) @(posedge clk_sys);
    tally_and_finish();
  end
endmodule : test_dcfc_port_ctrl
bind dcfc_port_ctrl dcfc_port_ctrl_chk i_chk (.*);
`default_nettype wire
